// ==== shared/psc_pkg.sv ====
/*
 Constants for the strap configuration latch: pin vector layout,
 register indexes, field positions and values after reset.
 Assumes a 32-bit classic Wishbone slave port, byte addressed.
*/
package psc_pkg;
    // positions in the synchronised pin vector
    localparam int SP_RSTN = 0;
    localparam int SP_ADDR = 1;
    localparam int SP_BCAST = 4;
    localparam int SP_ANEG = 5;
    localparam int SP_MODE = 6;
    localparam int SP_TXEN = 9;
    localparam int SP_TXD = 10;
    localparam int SP_TX_ERROR_LPI_REQUEST = 14;
    localparam int SP_W = 15;
    // register indexes, byte address is four times the index
    localparam logic [7:0] REG_BASIC_IDX = 8'h00;
    localparam logic [7:0] REG_SPECIAL_IDX = 8'h16;
    localparam logic [7:0] REG_STATUS_IDX = 8'h1F;
    // field positions
    localparam int F_ANEG = 12;
    localparam int F_ADDR0_UNIQUE = 9;
    localparam int F_EEE = 0;
    localparam int F_ST_MODE = 5;
    localparam int F_ST_BCAST = 8;
    localparam int F_ST_LPI = 9;
    localparam int F_ST_RUN = 10;
    // values after reset
    localparam logic [2:0] RST_ADDR_LOW = 3'h1;
    localparam logic [1:0] MGMT_ADDR_UPPER = 2'h0;
    localparam logic [2:0] RST_IF_MODE = 3'h0;
    localparam logic [2:0] IF_MODE_MII = 3'h0;
    localparam logic RST_ANEG = 1'b1;
    localparam logic RST_BCAST_OFF = 1'b0;
    localparam logic [14:0] RST_SYNC = 15'h0000;

    typedef enum logic [1:0] {
        CS_HELD = 2'b01,
        CS_RUN = 2'b10
    } psc_chip_e;
endpackage

// ==== core/psc_strap_latch.sv ====
/*
 Strap configuration latch with MII qualifier logic and a Wishbone
 register port. Straps and MII transmit pins come from outside the
 clock domain and are synchronised; the receive nibble source and
 management frame decoder sit on the same clock.
*/
// Summary of operation
// - tx error pin with enable low enters low-power idle when EEE on
// - tx error ignored outside EEE operation
// - receive nibble valid only with data valid
// - straps sampled at chip reset release, held
// - address low bits from three straps, default 1
// - address upper two bits forced to zero
// - address zero broadcast unless strap or software bit
// - interface mode latched, 000 selects plain MII
// - broadcast-off strap low keeps address zero broadcast
// - autoneg strap loads basic control bit 12
`timescale 1ns/1ns
module psc_strap_latch
    import psc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    // chip reset pin, active low
    input wire logic chipResetN,
    input wire logic mgmtAddrStrapBit2,
    input wire logic mgmtAddrStrapBit1,
    input wire logic mgmtAddrStrapBit0,
    input wire logic addrZeroUniqueStrap,
    input wire logic autonegEnableStrap,
    input wire logic [2:0] ifModeStrap,
    // MII transmit pins from the MAC
    input wire logic txEn,
    input wire logic [3:0] txData,
    input wire logic txErrorLpiRequest,
    // internal transmit path
    output logic [3:0] txNibble,
    output logic txNibbleValid,
    output logic lpiRequestActive,
    // internal receive path and MII receive pins
    input wire logic [3:0] rxNibbleIn,
    input wire logic rxNibbleValidIn,
    output logic [3:0] rxData,
    output logic rxDataValid,
    // management frame decoder
    input wire logic [4:0] mgmtFrameAddr,
    input wire logic mgmtFrameStrobe,
    output logic mgmtAddrHit,
    // configuration outputs
    output logic [4:0] mgmtAddress,
    output logic [2:0] ifMode,
    output logic autonegEnabled,
    // classic Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck
);
    typedef struct packed {
        logic [SP_W-1:0] sync1;
        logic [SP_W-1:0] sync2;
        psc_chip_e chip;
        logic [2:0] addrLow;
        logic [2:0] mode;
        logic bcastOff;
        logic aneg;
        logic swUnique;
        logic eee;
        logic lpi;
        logic [3:0] rxd;
        logic rxdv;
        logic [3:0] txd;
        logic txv;
        logic hit;
        logic ack;
        logic [31:0] dat;
    } psc_state_s;

    localparam psc_state_s RESET_STATE = '{
        sync1: RST_SYNC, sync2: RST_SYNC, chip: CS_HELD,
        addrLow: RST_ADDR_LOW, mode: RST_IF_MODE,
        bcastOff: RST_BCAST_OFF, aneg: RST_ANEG, swUnique: 1'b0,
        eee: 1'b0, lpi: 1'b0, rxd: 4'h0, rxdv: 1'b0, txd: 4'h0,
        txv: 1'b0, hit: 1'b0, ack: 1'b0, dat: 32'h0000_0000};

    psc_state_s cur_q;
    psc_state_s cur_d;

    // word register selected by a byte address
    function automatic logic hitsReg(input logic [7:0] adr,
                                     input logic [7:0] idx);
        hitsReg = (adr[7:2] == idx[5:0]) && (adr[1:0] == 2'h0);
    endfunction

    logic [SP_W-1:0] pinVec;
    logic running;
    logic releaseEdge;
    logic addrZeroBcast;
    logic [4:0] fullAddr;
    logic wbReq;

    // pins gathered for the two-stage synchroniser
    assign pinVec = {txErrorLpiRequest, txData, txEn, ifModeStrap,
                     autonegEnableStrap, addrZeroUniqueStrap,
                     mgmtAddrStrapBit2, mgmtAddrStrapBit1,
                     mgmtAddrStrapBit0, chipResetN};

    // derived state, only the second stage is read
    assign running = (cur_q.chip == CS_RUN);
    assign releaseEdge = (cur_q.chip == CS_HELD) && cur_q.sync2[SP_RSTN];
    assign fullAddr = {MGMT_ADDR_UPPER, cur_q.addrLow};
    // either strap or software bit makes address zero unique
    assign addrZeroBcast = !(cur_q.bcastOff || cur_q.swUnique);
    assign wbReq = wbCyc && wbStb && !cur_q.ack;

    // next-state logic for the whole block
    always_comb begin
        cur_d = cur_q;
        cur_d.sync1 = pinVec;
        cur_d.sync2 = cur_q.sync1;
        cur_d.ack = wbReq;
        cur_d.hit = 1'b0;
        unique case (cur_q.chip)
            CS_HELD: begin
                // config sampled on the release edge only
                if (cur_q.sync2[SP_RSTN]) begin
                    cur_d.chip = CS_RUN;
                    cur_d.addrLow = cur_q.sync2[SP_ADDR +: 3];
                    cur_d.mode = cur_q.sync2[SP_MODE +: 3];
                    cur_d.bcastOff = cur_q.sync2[SP_BCAST];
                    cur_d.aneg = cur_q.sync2[SP_ANEG];
                end
            end
            CS_RUN: begin
                // chip reset returns config to defaults
                if (!cur_q.sync2[SP_RSTN]) begin
                    cur_d = RESET_STATE;
                    cur_d.sync1 = pinVec;
                    cur_d.sync2 = cur_q.sync1;
                    cur_d.ack = wbReq;
                end
            end
            default: begin
                cur_d.chip = CS_HELD;
            end
        endcase
        // receive nibble zeroed outside data valid
        cur_d.rxdv = running && rxNibbleValidIn;
        cur_d.rxd = (running && rxNibbleValidIn) ? rxNibbleIn : 4'h0;
        // transmit nibble passed on only while enabled
        cur_d.txv = running && cur_q.sync2[SP_TXEN];
        cur_d.txd = cur_d.txv ? cur_q.sync2[SP_TXD +: 4] : 4'h0;
        // error pin means idle request only with EEE on
        cur_d.lpi = running && cur_q.eee && cur_q.sync2[SP_TX_ERROR_LPI_REQUEST]
                    && !cur_q.sync2[SP_TXEN];
        // frame address compare with broadcast zero
        cur_d.hit = running && mgmtFrameStrobe
                    && ((mgmtFrameAddr == fullAddr)
                        || (mgmtFrameAddr == 5'h00 && addrZeroBcast));
        // register writes, taken with the ack; a chip reset seen this cycle wins
        if (wbReq && wbWe && running && cur_q.sync2[SP_RSTN]) begin
            if (hitsReg(wbAdr, REG_BASIC_IDX) && wbSel[1]) begin
                cur_d.aneg = wbDatIn[F_ANEG];
            end
            if (hitsReg(wbAdr, REG_SPECIAL_IDX)) begin
                if (wbSel[1]) begin
                    cur_d.swUnique = wbDatIn[F_ADDR0_UNIQUE];
                end
                if (wbSel[0]) begin
                    cur_d.eee = wbDatIn[F_EEE];
                end
            end
        end
        // register reads, unmapped reads as zero
        cur_d.dat = 32'h0000_0000;
        if (wbReq && !wbWe) begin
            if (hitsReg(wbAdr, REG_BASIC_IDX)) begin
                cur_d.dat[F_ANEG] = cur_q.aneg;
            end else if (hitsReg(wbAdr, REG_SPECIAL_IDX)) begin
                cur_d.dat[F_ADDR0_UNIQUE] = cur_q.swUnique;
                cur_d.dat[F_EEE] = cur_q.eee;
            end else if (hitsReg(wbAdr, REG_STATUS_IDX)) begin
                cur_d.dat[4:0] = fullAddr;
                cur_d.dat[F_ST_MODE +: 3] = cur_q.mode;
                cur_d.dat[F_ST_BCAST] = addrZeroBcast;
                cur_d.dat[F_ST_LPI] = cur_q.lpi;
                cur_d.dat[F_ST_RUN] = running;
            end
        end
    end

    // single state register
    always_ff @(posedge clock) begin
        if (srst) begin
            cur_q <= RESET_STATE;
        end else begin
            cur_q <= cur_d;
        end
    end

    // outputs all come from the state register
    assign txNibble = cur_q.txd;
    assign txNibbleValid = cur_q.txv;
    assign lpiRequestActive = cur_q.lpi;
    assign rxData = cur_q.rxd;
    assign rxDataValid = cur_q.rxdv;
    assign mgmtAddrHit = cur_q.hit;
    assign mgmtAddress = fullAddr;
    assign ifMode = cur_q.mode;
    assign autonegEnabled = cur_q.aneg;
    assign wbDatOut = cur_q.dat;
    assign wbAck = cur_q.ack;

    // checks next to the logic
    a_lpi_enter: assert property (@(posedge clock) disable iff (srst)
        (running && cur_q.eee && cur_q.sync2[SP_TX_ERROR_LPI_REQUEST] && !cur_q.sync2[SP_TXEN]
         && cur_q.sync2[SP_RSTN]) |=> lpiRequestActive)
        else $error("idle request not honoured");

    a_lpi_noneee: assert property (@(posedge clock) disable iff (srst)
        !cur_q.eee |=> !lpiRequestActive)
        else $error("tx error acted on outside EEE");

    a_rx_gated: assert property (@(posedge clock) disable iff (srst)
        !rxDataValid |-> rxData == 4'h0)
        else $error("rx data without valid");

    a_rx_follow: assert property (@(posedge clock) disable iff (srst)
        (running && cur_q.sync2[SP_RSTN] && rxNibbleValidIn)
        |=> rxDataValid && rxData == $past(rxNibbleIn))
        else $error("rx nibble not forwarded");

    a_tx_gated: assert property (@(posedge clock) disable iff (srst)
        !txNibbleValid |-> txNibble == 4'h0)
        else $error("tx nibble without enable");

    a_strap_latch: assert property (@(posedge clock) disable iff (srst)
        releaseEdge |=> mgmtAddress[2:0] == $past(cur_q.sync2[SP_ADDR +: 3])
        && ifMode == $past(cur_q.sync2[SP_MODE +: 3])
        && autonegEnabled == $past(cur_q.sync2[SP_ANEG]))
        else $error("straps not latched at release");

    a_addr_hold: assert property (@(posedge clock) disable iff (srst)
        (running && $past(running)) |-> $stable(mgmtAddress) && $stable(ifMode))
        else $error("latched config changed while running");

    a_addr_upper: assert property (@(posedge clock) disable iff (srst)
        mgmtAddress[4:3] == MGMT_ADDR_UPPER)
        else $error("upper address bits not zero");

    a_bcast_zero: assert property (@(posedge clock) disable iff (srst)
        (running && cur_q.sync2[SP_RSTN] && mgmtFrameStrobe && mgmtFrameAddr == 5'h00
         && !cur_q.bcastOff && !cur_q.swUnique) |=> mgmtAddrHit)
        else $error("broadcast address zero missed");

    a_unique_zero: assert property (@(posedge clock) disable iff (srst)
        (mgmtFrameStrobe && mgmtFrameAddr == 5'h00 && fullAddr != 5'h00
         && (cur_q.bcastOff || cur_q.swUnique)) |=> !mgmtAddrHit)
        else $error("address zero treated as broadcast");

    a_wb_ack_once: assert property (@(posedge clock) disable iff (srst)
        wbAck |=> !wbAck)
        else $error("ack held two cycles");
endmodule

// ==== tb/psc_mac_model.sv ====
/*
 MAC side of the MII transmit pins: nibbles with enable, idle and
 the low-power idle request on the error pin.
 Assumes tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ns
module psc_mac_model (
    input wire logic clock,
    output logic txEn,
    output logic [3:0] txData,
    output logic txErr
);
    logic [3:0] lastData;
    // pins idle after power-up, error pin low as its pull-down
    initial begin
        txEn = 1'b0;
        txData = 4'hF;
        txErr = 1'b0;
        lastData = 4'h0;
    end
    // data changes only right after an edge, with enable up
    task automatic send(input logic [3:0] d);
        txEn <= 1'b1;
        txData <= d;
        lastData = d;
    endtask
    // released data shows the inverse, so stale nibbles never look valid
    task automatic idle(input logic err);
        txEn <= 1'b0;
        txData <= ~lastData;
        txErr <= err;
    endtask
endmodule

// ==== tb/psc_strap_latch_test.sv ====
/*
 Self-checking bench for the strap latch: straps, chip reset,
 management hits, MII paths and Wishbone registers.
 Assumes no fixed Wishbone latency; waits for the ack under the hang guard.
*/
`timescale 1ns/1ns
module psc_strap_latch_test;
    import psc_pkg::*;
    logic clock, srst, chipResetN, b2, b1, b0, uniq, aneg;
    logic [2:0] mode;
    logic txEn, txErr, rxVin, strobe, hit, txV, lpi, rxV, anegOn;
    logic [3:0] txData, txNib, rxIn, rxData;
    logic [4:0] frameAddr, addr;
    logic [2:0] ifMode;
    logic wbCyc, wbStb, wbWe, wbAck;
    logic [7:0] wbAdr;
    logic [31:0] wbDatIn, wbDatOut, q;
    int nMismatch = 0;
    int samplesChecked = 0;
    int cyc = 0;
    psc_mac_model mac (.clock(clock), .txEn(txEn), .txData(txData), .txErr(txErr));
    psc_strap_latch uut (.clock(clock), .srst(srst), .chipResetN(chipResetN),
        .mgmtAddrStrapBit2(b2), .mgmtAddrStrapBit1(b1), .mgmtAddrStrapBit0(b0),
        .addrZeroUniqueStrap(uniq), .autonegEnableStrap(aneg), .ifModeStrap(mode),
        .txEn(txEn), .txData(txData), .txErrorLpiRequest(txErr), .txNibble(txNib),
        .txNibbleValid(txV), .lpiRequestActive(lpi), .rxNibbleIn(rxIn),
        .rxNibbleValidIn(rxVin), .rxData(rxData), .rxDataValid(rxV),
        .mgmtFrameAddr(frameAddr), .mgmtFrameStrobe(strobe), .mgmtAddrHit(hit),
        .mgmtAddress(addr), .ifMode(ifMode), .autonegEnabled(anegOn), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hF), .wbDatIn(wbDatIn),
        .wbDatOut(wbDatOut), .wbAck(wbAck));
    // free-running 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            nMismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    // classic cycle; ack and data are sampled as the edge arrives
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatIn <= d;
        // no fixed latency assumed, the hang guard ends a lost answer
        do begin
            @(posedge clock);
        end while (wbAck !== 1'b1);
        q = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clock);
    endtask
    task automatic mg(input logic [4:0] a, input logic exp);
        strobe <= 1'b1;
        frameAddr <= a;
        step(1);
        strobe <= 1'b0;
        step(1);
        chk(32'(hit), 32'(exp));
    endtask
    // straps set while chip reset is low, then released
    task automatic boot(input logic [2:0] ad, input logic u, input logic an,
                        input logic [2:0] md);
        chipResetN <= 1'b0;
        {b2, b1, b0} <= ad;
        uniq <= u;
        aneg <= an;
        mode <= md;
        step(4);
        chipResetN <= 1'b1;
        step(6);
        {b2, b1, b0, uniq, aneg, mode} <= 9'h0FF;
        step(4);
    endtask
    initial begin
        srst = 1'b1;
        {chipResetN, b2, b1, b0, uniq, aneg, mode, rxVin, strobe} = '0;
        {rxIn, frameAddr, wbCyc, wbStb, wbWe, wbAdr, wbDatIn} = '0;
        step(8);
        srst <= 1'b0;
        step(2);
        chk(32'({MGMT_ADDR_UPPER, RST_ADDR_LOW, RST_IF_MODE, RST_ANEG}), 32'h11);
        wb(1'b1, 8'h58, 32'h201); // dropped while held
        wb(1'b0, 8'h58, 32'h0);
        chk(q, 32'h0);
        $display("test defaults done");
        boot(3'h5, 1'b0, 1'b0, 3'h0);
        chk(32'({addr, ifMode, anegOn}), 32'h50);
        wb(1'b0, 8'h7C, 32'h0);
        chk(q, 32'h505);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        mg(5'h05, 1'b1);
        mg(5'h00, 1'b1);
        mg(5'h06, 1'b0);
        wb(1'b1, 8'h00, 32'h1000);
        chk(32'(anegOn), 32'h1);
        $display("test latch done");
        mac.send(4'hA);
        step(5);
        chk(32'({txV, txNib}), 32'h1A);
        mac.idle(1'b1);
        step(5);
        chk(32'({txV, txNib, lpi}), 32'h0);
        wb(1'b1, 8'h58, 32'h1);
        step(3);
        chk(32'(lpi), 32'h1);
        wb(1'b1, 8'h58, 32'h201);
        mg(5'h00, 1'b0);
        wb(1'b0, 8'h7C, 32'h0);
        chk(q, 32'h605);
        mac.idle(1'b0);
        $display("test transmit done");
        rxVin <= 1'b1;
        rxIn <= 4'h5;
        step(2);
        chk(32'({rxV, rxData}), 32'h15);
        rxVin <= 1'b0;
        rxIn <= 4'hC;
        step(2);
        chk(32'({rxV, rxData}), 32'h0);
        $display("test receive done");
        boot(3'h7, 1'b1, 1'b1, 3'h6);
        chk(32'({addr, ifMode, anegOn}), 32'h7D);
        wb(1'b0, 8'h7C, 32'h0);
        chk(q, 32'h4C7);
        mg(5'h00, 1'b0);
        mg(5'h07, 1'b1);
        $display("test restrap done");
        wrap_up();
    end
endmodule
